// File: verilog/ars_timer.sv
// Purpose: async real-time counter with staged writes and wake-up
// Assumes: clk_i well above four times the oscillator rate
// Notes:   oscillator pin is sampled, edges act as timer enables
`timescale 1ns/10ps
module ars_timer (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // register bus
  input  wire ars_pkg::ars_axi_req_t axi_req_i,
  output wire ars_pkg::ars_axi_rsp_t axi_rsp_o,
  // oscillator and pins
  input  wire logic                 osc_in_pin_i,
  output logic                      osc_enable_o,
  output logic                      pins_owned_o,
  output logic                      oc_pin_o,
  // processor side
  input  wire ars_pkg::ars_sleep_t  sleep_mode_i,
  input  wire logic                 global_irq_en_i,
  input  wire logic                 cmp_irq_ack_i,
  input  wire logic                 ovf_irq_ack_i,
  output logic                      cmp_irq_o,
  output logic                      ovf_irq_o,
  output logic                      wake_o,
  output logic                      cpu_stall_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       osc_s1_r, osc_s2_r, osc_s3_r, osc_rise;
  logic       async_r, psr_r, src_tick, tick;
  logic [9:0] pre_r, pre_mask;
  logic [7:0] count_r, cmp_r, ctrl_r, snap_r, mask_r, flag_r;
  logic [7:0] stage_r [3];
  logic [2:0] busy_r, wr_en, xfer;
  logic [1:0] ecnt_r [3];
  logic       dir_r, cmp_evt, ovf_evt, cmp_set, ovf_set;
  logic [ars_pkg::FLAG_SYNC_CYC-2:0] cmp_p_r, ovf_p_r;
  logic       armed_r, wpend_r, wake_fire, deep_save;
  logic [2:0] stall_cnt_r;
  logic       awrdy_r, wrdy_r, aw_full_r, w_full_r, bvalid_r;
  logic       arrdy_r, rvalid_r, do_wr, aw_hs, w_hs, ar_hs;
  logic [7:0] awaddr_r, wdata_r, rdata_r, rd_mux;
  logic       wstrb_r, bad_w, rd_bad;
  logic [1:0] bresp_r, rresp_r;

  localparam int unsigned FLAG_SYNC_CYC = ars_pkg::FLAG_SYNC_CYC;

  // ---------------------------------------------------------------
  // oscillator pin sampling
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_in_pin_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  assign osc_rise = osc_s2_r & ~osc_s3_r & async_r;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign aw_hs = axi_req_i.awvalid & awrdy_r;
  assign w_hs  = axi_req_i.wvalid & wrdy_r;
  assign ar_hs = axi_req_i.arvalid & arrdy_r;
  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign bad_w = awaddr_r > ars_pkg::OFS_SPECIAL || awaddr_r[1:0] != 2'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awrdy_r   <= 1'b0;
      wrdy_r    <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ars_pkg::RESP_OK;
      awaddr_r  <= ars_pkg::RST_BYTE;
      wdata_r   <= ars_pkg::RST_BYTE;
      wstrb_r   <= 1'b0;
    end else begin
      aw_full_r <= ~do_wr & (aw_full_r | aw_hs);
      w_full_r  <= ~do_wr & (w_full_r | w_hs);
      awrdy_r   <= do_wr | ~(aw_full_r | aw_hs);
      wrdy_r    <= do_wr | ~(w_full_r | w_hs);
      bvalid_r  <= do_wr | (bvalid_r & ~axi_req_i.bready);
      if (do_wr) begin
        bresp_r <= bad_w ? ars_pkg::RESP_ERR : ars_pkg::RESP_OK;
      end
      if (aw_hs) begin
        awaddr_r <= axi_req_i.awaddr;
      end
      if (w_hs) begin
        wdata_r <= axi_req_i.wdata[7:0];
        wstrb_r <= axi_req_i.wstrb[0];
      end
    end
  end

  // read mux; narrow registers in the low byte
  always_comb begin
    rd_mux = ars_pkg::RST_BYTE;
    rd_bad = 1'b0;
    case (axi_req_i.araddr)
      ars_pkg::OFS_COUNT:   rd_mux = async_r ? snap_r : count_r;
      ars_pkg::OFS_COMPARE: rd_mux = stage_r[1];
      ars_pkg::OFS_CONTROL: rd_mux = stage_r[2];
      ars_pkg::OFS_ASYNC:   rd_mux = {4'h0, async_r, busy_r[2:0]};
      ars_pkg::OFS_MASK:    rd_mux = mask_r;
      ars_pkg::OFS_FLAGS:   rd_mux = flag_r;
      // reset bit reads zero when synchronous
      ars_pkg::OFS_SPECIAL: rd_mux = {6'h00, psr_r & async_r, 1'b0};
      default:              rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arrdy_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= ars_pkg::RST_BYTE;
      rresp_r  <= ars_pkg::RESP_OK;
    end else begin
      rvalid_r <= ar_hs | (rvalid_r & ~axi_req_i.rready);
      arrdy_r  <= ~(ar_hs | (rvalid_r & ~axi_req_i.rready));
      if (ar_hs) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_bad ? ars_pkg::RESP_ERR : ars_pkg::RESP_OK;
      end
    end
  end

  assign axi_rsp_o = '{awready: awrdy_r, wready: wrdy_r,
                       bvalid: bvalid_r, bresp: bresp_r,
                       arready: arrdy_r, rvalid: rvalid_r,
                       rdata: {24'h000000, rdata_r}, rresp: rresp_r};

  // ---------------------------------------------------------------
  // staging registers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stage
      assign wr_en[gi] = do_wr & wstrb_r &
                         awaddr_r == 8'(4 * gi);
      // two oscillator edges in async mode
      assign xfer[gi] = busy_r[gi] & (~async_r |
                        (osc_rise & ecnt_r[gi] ==
                         2'(ars_pkg::XFER_EDGES - 1)));
      // busy set on write, cleared on transfer
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          stage_r[gi] <= ars_pkg::RST_BYTE;
          busy_r[gi]  <= 1'b0;
          ecnt_r[gi]  <= 2'h0;
        end else if (wr_en[gi]) begin
          stage_r[gi] <= wdata_r;
          busy_r[gi]  <= 1'b1;
          ecnt_r[gi]  <= 2'h0;
        end else if (xfer[gi]) begin
          busy_r[gi] <= 1'b0;
        end else if (osc_rise && busy_r[gi]) begin
          ecnt_r[gi] <= ecnt_r[gi] + 2'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_r  <= ars_pkg::RST_BYTE;
      ctrl_r <= ars_pkg::RST_BYTE;
    end else begin
      if (xfer[1]) begin
        cmp_r <= stage_r[1];
      end
      if (xfer[2]) begin
        ctrl_r <= stage_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // clock source, prescaler and counter
  // ---------------------------------------------------------------
  // io clock by default, oscillator when selected
  assign src_tick = async_r ? osc_rise : 1'b1;

  always_comb begin
    case (ctrl_r[2:0])
      3'h2:    pre_mask = 10'h007;
      3'h3:    pre_mask = 10'h01F;
      3'h4:    pre_mask = 10'h03F;
      3'h5:    pre_mask = 10'h07F;
      3'h6:    pre_mask = 10'h0FF;
      3'h7:    pre_mask = 10'h3FF;
      default: pre_mask = 10'h000;
    endcase
  end
  assign tick = src_tick & ctrl_r[2:0] != 3'h0 &
                (pre_r & pre_mask) == pre_mask;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r <= 10'h000;
    end else if (psr_r && (!async_r || osc_rise)) begin
      pre_r <= 10'h000;
    end else if (src_tick) begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // bit held until the async reset is done
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psr_r   <= 1'b0;
      async_r <= 1'b0;
      mask_r  <= ars_pkg::RST_BYTE;
    end else begin
      if (do_wr && wstrb_r && awaddr_r == ars_pkg::OFS_SPECIAL &&
          wdata_r[ars_pkg::PSR_BIT]) begin
        psr_r <= 1'b1;
      end else if (!async_r || osc_rise) begin
        psr_r <= 1'b0;
      end
      if (do_wr && wstrb_r && awaddr_r == ars_pkg::OFS_ASYNC) begin
        async_r <= wdata_r[ars_pkg::ASEL_BIT];
      end
      if (do_wr && wstrb_r && awaddr_r == ars_pkg::OFS_MASK) begin
        mask_r <= wdata_r;
      end
    end
  end

  // no match while count or compare pending
  assign cmp_evt = tick & count_r == cmp_r & ~busy_r[0] & ~busy_r[1];
  // wrap, or bottom reached while still counting down in PWM mode
  assign ovf_evt = tick & (ctrl_r[ars_pkg::PWM_BIT] ?
                   (~dir_r & count_r == ars_pkg::CNT_BOT) :
                   count_r == ars_pkg::CNT_TOP);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= ars_pkg::RST_BYTE;
      dir_r   <= 1'b1;
      snap_r  <= ars_pkg::RST_BYTE;
    end else begin
      if (xfer[0]) begin
        count_r <= stage_r[0];
      end else if (tick) begin
        if (!ctrl_r[ars_pkg::PWM_BIT] || dir_r) begin
          count_r <= count_r + 8'h01;
        end else begin
          count_r <= count_r - 8'h01;
        end
      end
      if (tick && ctrl_r[ars_pkg::PWM_BIT]) begin
        if (count_r == ars_pkg::CNT_TOP - 8'h01 && dir_r) begin
          dir_r <= 1'b0;
        end else if (count_r == ars_pkg::CNT_BOT + 8'h01 && !dir_r) begin
          dir_r <= 1'b1;
        end
      end
      if (osc_rise) begin
        snap_r <= count_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags and interrupt requests
  // ---------------------------------------------------------------
  // extra crossing delay in async mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_p_r <= '0;
      ovf_p_r <= '0;
    end else begin
      cmp_p_r <= {cmp_p_r[FLAG_SYNC_CYC-3:0], cmp_evt & async_r};
      ovf_p_r <= {ovf_p_r[FLAG_SYNC_CYC-3:0], ovf_evt & async_r};
    end
  end
  assign cmp_set = async_r ? cmp_p_r[FLAG_SYNC_CYC-2] : cmp_evt;
  assign ovf_set = async_r ? ovf_p_r[FLAG_SYNC_CYC-2] : ovf_evt;

  // compare flag, set wins over clear
  // overflow flag, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= ars_pkg::RST_BYTE;
    end else begin
      if (cmp_set) begin
        flag_r[ars_pkg::CMP_BIT] <= 1'b1;
      end else if (cmp_irq_ack_i || (do_wr && wstrb_r &&
               awaddr_r == ars_pkg::OFS_FLAGS &&
               wdata_r[ars_pkg::CMP_BIT])) begin
        flag_r[ars_pkg::CMP_BIT] <= 1'b0;
      end
      if (ovf_set) begin
        flag_r[ars_pkg::OVF_BIT] <= 1'b1;
      end else if (ovf_irq_ack_i || (do_wr && wstrb_r &&
               awaddr_r == ars_pkg::OFS_FLAGS &&
               wdata_r[ars_pkg::OVF_BIT])) begin
        flag_r[ars_pkg::OVF_BIT] <= 1'b0;
      end
    end
  end

  // enable, flag and global bit all set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_irq_o <= 1'b0;
      ovf_irq_o <= 1'b0;
    end else begin
      cmp_irq_o <= mask_r[ars_pkg::CMP_BIT] &
                   flag_r[ars_pkg::CMP_BIT] & global_irq_en_i;
      ovf_irq_o <= mask_r[ars_pkg::OVF_BIT] &
                   flag_r[ars_pkg::OVF_BIT] & global_irq_en_i;
    end
  end

  // ---------------------------------------------------------------
  // pins, sleep and wake-up
  // ---------------------------------------------------------------
  assign deep_save = sleep_mode_i == ars_pkg::ARS_SLP_PSAVE ||
                     sleep_mode_i == ars_pkg::ARS_SLP_EXTSB;
  assign wake_fire = wpend_r & osc_rise;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_enable_o <= 1'b0;
      pins_owned_o <= 1'b0;
      oc_pin_o     <= 1'b0;
      armed_r      <= 1'b1;
      wpend_r      <= 1'b0;
      wake_o       <= 1'b0;
      stall_cnt_r  <= 3'h0;
      cpu_stall_o  <= 1'b0;
    end else begin
      // on in async mode only, and off there in power-down and standby
      osc_enable_o <= async_r &
                      sleep_mode_i != ars_pkg::ARS_SLP_PDOWN &
                      sleep_mode_i != ars_pkg::ARS_SLP_STDBY;
      // pins leave the port in async mode
      pins_owned_o <= async_r;
      // compare pin toggles on compare match when OCTOG_BIT is set
      if (cmp_evt && ctrl_r[ars_pkg::OCTOG_BIT]) begin
        oc_pin_o <= ~oc_pin_o;
      end
      // rearm one oscillator cycle after wake
      armed_r <= wake_fire ? 1'b0 : (osc_rise | armed_r);
      // wake on the next timer clock edge
      wpend_r <= ~wake_fire & deep_save & (wpend_r | (armed_r &
                 (cmp_irq_o | ovf_irq_o)));
      wake_o  <= wake_fire;
      if (wake_fire) begin
        stall_cnt_r <= 3'(ars_pkg::STALL_CYC);
      end else if (stall_cnt_r != 3'h0) begin
        stall_cnt_r <= stall_cnt_r - 3'h1;
      end
      cpu_stall_o <= wake_fire | stall_cnt_r > 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_cmp_transfer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmp_r != $past(cmp_r) |-> $past(busy_r[1] &&
      (!async_r || (osc_rise && ecnt_r[1] == 2'h1))))
    else $error("compare loaded without staged transfer");

  a_busy_on_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_en[2] |=> busy_r[2] && stage_r[2] == $past(wdata_r))
    else $error("control busy not set on write");

  a_match_blocked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (busy_r[0] || busy_r[1]) |-> !cmp_evt)
    else $error("compare match while write pending");

  a_wake_edge: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o |-> $past(osc_rise) && $past(wpend_r))
    else $error("wake not on timer edge");

  a_stall_four: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o |-> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("stall not four cycles");

  a_flag_delay: assert property (
    @(posedge clk_i) disable iff (rst_i)
    async_r && cmp_evt ##1 async_r [*2] |=>
      flag_r[ars_pkg::CMP_BIT])
    else $error("compare flag crossing delay wrong");

  a_irq_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ovf_irq_o |-> $past(mask_r[ars_pkg::OVF_BIT] &&
      flag_r[ars_pkg::OVF_BIT] && global_irq_en_i))
    else $error("overflow irq without enable");

  a_psr_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    async_r && psr_r && !osc_rise ##1 async_r |-> psr_r)
    else $error("prescaler reset bit dropped early");

  a_oc_pin_src: assert property (
    @(posedge clk_i) disable iff (rst_i)
    oc_pin_o != $past(oc_pin_o) |-> $past(cmp_evt))
    else $error("compare pin moved without match");

  a_wake_rearm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o |-> !armed_r)
    else $error("wake logic not cleared after wake");

endmodule : ars_timer

// File: verilog/ars_pkg.sv
// Purpose: shared constants and types of the async real-time counter
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes:   registers sit in the low byte of each word
package ars_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned XFER_EDGES    = 2;  // osc edges per transfer
  localparam int unsigned STALL_CYC     = 4;  // cpu halt after wake
  localparam int unsigned FLAG_SYNC_CYC = 3;  // flag crossing cycles

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT   = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ASYNC   = 8'h0C;
  localparam logic [7:0] OFS_MASK    = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_SPECIAL = 8'h18;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CMP_BIT   = 7;  // mask and flag registers
  localparam int unsigned OVF_BIT   = 6;
  localparam int unsigned ASEL_BIT  = 3;  // async status register
  localparam int unsigned PSR_BIT   = 1;  // special io register
  localparam int unsigned PWM_BIT   = 6;  // control register
  localparam int unsigned OCTOG_BIT = 4;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  CNT_TOP   = 8'hFF;
  localparam logic [7:0]  CNT_BOT   = 8'h00;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ARS_SLP_NONE  = 3'h0,
    ARS_SLP_IDLE  = 3'h1,
    ARS_SLP_PSAVE = 3'h3,
    ARS_SLP_EXTSB = 3'h2,
    ARS_SLP_STDBY = 3'h6,
    ARS_SLP_PDOWN = 3'h7
  } ars_sleep_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ars_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ars_axi_rsp_t;

endpackage : ars_pkg

// File: dv/ars_osc_model.sv
// Purpose: watch crystal stand-in driving the oscillator pin
// Assumes: run input high lets the crystal swing
// Notes:   pin rests low while the crystal is stopped
`timescale 1ns/10ps
module ars_osc_model #(
  parameter int HALF_NS = 2000
) (
  input  wire logic run_i,
  output logic      osc_o
);
  // period far above four cpu clocks
  initial begin
    osc_o = 1'b0;
    forever begin
      #(HALF_NS);
      osc_o = run_i ? ~osc_o : 1'b0;
    end
  end
endmodule : ars_osc_model

// File: dv/ars_timer_tb_top.sv
// Purpose: register-level bench of the async real-time counter
// Assumes: crystal model period of 200 clocks
// Notes:   sync mode first, then async staging and wake
`timescale 1ns/10ps
module ars_timer_tb_top;
  logic                  clk_i;
  logic                  rst_i;
  ars_pkg::ars_axi_req_t req;
  ars_pkg::ars_axi_rsp_t rsp;
  ars_pkg::ars_sleep_t   slp;
  logic                  osc, osc_en, owned, oc_pin;
  logic                  gie, cack, oack, cirq, oirq, wake, stall;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    n_fail, n_tests, rises, k, i, n;

  ars_timer dut (
    .clk_i(clk_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .osc_in_pin_i(osc), .osc_enable_o(osc_en), .pins_owned_o(owned),
    .oc_pin_o(oc_pin), .sleep_mode_i(slp), .global_irq_en_i(gie),
    .cmp_irq_ack_i(cack), .ovf_irq_ack_i(oack), .cmp_irq_o(cirq),
    .ovf_irq_o(oirq), .wake_o(wake), .cpu_stall_o(stall)
  );
  ars_osc_model osc_m (.run_i(osc_en), .osc_o(osc));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge osc) rises++;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_fail++;
    $display("Error %0t: wait ran out", $time);
    stop_test();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int j;
    @(posedge clk_i);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, v};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    if (j == 50) hang();
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int j;
    @(posedge clk_i);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (j == 50) hang();
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic poll(input logic [7:0] a, m, e);
    int j;
    for (j = 0; j < 400; j++) begin
      rd(a);
      if ((d[7:0] & m) === e) break;
    end
    if (j == 400) hang();
  endtask : poll

  // bounded wait for the next crystal rising edge
  task automatic osc_edge();
    int j;
    int k0;
    k0 = rises;
    for (j = 0; j < 400; j++) begin
      @(posedge clk_i);
      if (rises != k0) break;
    end
    if (j == 400) hang();
  endtask : osc_edge

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    req   = '0;
    slp   = ars_pkg::ARS_SLP_NONE;
    gie   = 1'b0;
    cack  = 1'b0;
    oack  = 1'b0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ars_pkg::OFS_FLAGS);
    chk(d, 32'h00000000);
    rd(8'h1C);
    chk(r, ars_pkg::RESP_ERR);
    wr(ars_pkg::OFS_COMPARE, 8'h10);
    rd(ars_pkg::OFS_COMPARE);
    chk(d, 32'h00000010);
    wr(ars_pkg::OFS_SPECIAL, 8'h02);
    rd(ars_pkg::OFS_SPECIAL);
    chk(d, 32'h00000000);
    wr(ars_pkg::OFS_COUNT, 8'h00);
    wr(ars_pkg::OFS_CONTROL, 8'h01);
    poll(ars_pkg::OFS_FLAGS, 8'h80, 8'h80);
    poll(ars_pkg::OFS_FLAGS, 8'h40, 8'h40);
    chk(cirq, 1'b0);
    wr(ars_pkg::OFS_MASK, 8'hC0);
    gie <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(cirq, 1'b1);
    chk(oirq, 1'b1);
    wr(ars_pkg::OFS_CONTROL, 8'h00);
    @(posedge clk_i);
    cack <= 1'b1;
    @(posedge clk_i);
    cack <= 1'b0;
    rd(ars_pkg::OFS_FLAGS);
    chk(d, 32'h00000040);
    oack <= 1'b1;
    @(posedge clk_i);
    oack <= 1'b0;
    rd(ars_pkg::OFS_FLAGS);
    chk(d, 32'h00000000);
    gie <= 1'b0;
    wr(ars_pkg::OFS_ASYNC, 8'h08);
    @(posedge clk_i);
    chk(owned, 1'b1);
    chk(osc_en, 1'b1);
    osc_edge();
    repeat (10) @(posedge clk_i);
    k = rises;
    wr(ars_pkg::OFS_COMPARE, 8'h33);
    wr(ars_pkg::OFS_COUNT, 8'h40);
    rd(ars_pkg::OFS_ASYNC);
    chk(d, 32'h0000000B);
    poll(ars_pkg::OFS_ASYNC, 8'h07, 8'h00);
    chk(rises - k, 2);
    rd(ars_pkg::OFS_COMPARE);
    chk(d, 32'h00000033);
    osc_edge();
    repeat (10) @(posedge clk_i);
    rd(ars_pkg::OFS_COUNT);
    chk(d, 32'h00000040);
    wr(ars_pkg::OFS_SPECIAL, 8'h02);
    rd(ars_pkg::OFS_SPECIAL);
    chk(d, 32'h00000002);
    poll(ars_pkg::OFS_SPECIAL, 8'h02, 8'h00);
    wr(ars_pkg::OFS_COUNT, 8'h00);
    wr(ars_pkg::OFS_COMPARE, 8'h08);
    wr(ars_pkg::OFS_CONTROL, 8'h01);
    poll(ars_pkg::OFS_ASYNC, 8'h07, 8'h00);
    wr(ars_pkg::OFS_FLAGS, 8'hC0);
    wr(ars_pkg::OFS_MASK, 8'h80);
    gie <= 1'b1;
    slp <= ars_pkg::ARS_SLP_PSAVE;
    for (i = 0; i < 5000; i++) begin
      @(posedge clk_i);
      if (wake === 1'b1) break;
    end
    if (i == 5000) hang();
    chk(osc_en, 1'b1);
    n = 0;
    while (stall === 1'b1 && n < 10) begin
      n++;
      @(posedge clk_i);
    end
    chk(n, 4);
    wr(ars_pkg::OFS_FLAGS, 8'h80);
    rd(ars_pkg::OFS_FLAGS);
    chk(d, 32'h00000000);
    slp <= ars_pkg::ARS_SLP_PDOWN;
    repeat (3) @(posedge clk_i);
    chk(osc_en, 1'b0);
    slp <= ars_pkg::ARS_SLP_NONE;
    wr(ars_pkg::OFS_CONTROL, 8'h00);
    poll(ars_pkg::OFS_ASYNC, 8'h07, 8'h00);
    stop_test();
  end
endmodule : ars_timer_tb_top
